// ### shared/nvic_params.svh
// offsets, field positions, exception numbers and reset values of the interrupt controller
`ifndef NVIC_PARAMS_SVH
`define NVIC_PARAMS_SVH

`define NVIC_ADDR_W          12
`define NVIC_OFF_SETEN       12'h100
`define NVIC_OFF_CLREN       12'h180
`define NVIC_OFF_SETPEND     12'h200
`define NVIC_OFF_CLRPEND     12'h280
`define NVIC_OFF_PRIO_BASE   12'h400
`define NVIC_PRIO_REGS       8
`define NVIC_OFF_CTRL        12'hd04
`define NVIC_OFF_SYSPRIO2    12'hd1c
`define NVIC_OFF_SYSPRIO3    12'hd20

`define NVIC_EXC_COUNT       48
`define NVIC_EXC_NMI         6'h02
`define NVIC_EXC_FAULT       6'h03
`define NVIC_EXC_SVC         6'h0b
`define NVIC_EXC_DEFER       6'h0e
`define NVIC_EXC_TICK        6'h0f
`define NVIC_EXC_IRQ_BASE    6'h10

`define NVIC_RANK_NMI        3'h1
`define NVIC_RANK_FAULT      3'h2
`define NVIC_RANK_CFG_BASE   3'h3
`define NVIC_RANK_NONE       3'h7

`define NVIC_PRIO_MSB        7
`define NVIC_PRIO_LSB        6
`define NVIC_PRIO_RESET      2'h0

`define NVIC_LINE_BROWNOUT   0
`define NVIC_LINE_WATCHDOG   1
`define NVIC_LINE_EXT_A      2
`define NVIC_LINE_EXT_B      3
`define NVIC_LINE_PORT_LOW   4
`define NVIC_LINE_PORT_MID   5
`define NVIC_LINE_PORT_HIGH  16
`define NVIC_LINE_COMPARATOR 25
`define NVIC_LINE_PWR_WAKE   28

`define NVIC_WAKE_MASK       32'h1201_133f
`define NVIC_SYS_EN_MASK     16'hc80c
`define NVIC_VTOR_BASE       32'h0000_0000

`define NVIC_CTRL_DEFER_SET  28
`define NVIC_CTRL_DEFER_CLR  27
`define NVIC_CTRL_DEFER_PEND 26

`endif

// ### shared/nvic_pkg.sv
// types carried between the interrupt controller and its neighbours, and the controller's own register state
`default_nettype none
package nvic_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} nvic_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} nvic_apb_rsp_s;

	typedef struct packed {
		logic        brownout_irq;
		logic        watchdog_irq;
		logic        ext_pin_irq_a;
		logic        ext_pin_irq_b;
		logic        port_group_low_irq;
		logic        port_group_mid_irq;
		logic        port_group_high_irq;
		logic        comparator_irq;
		logic        power_wakeup_irq;
		logic [31:0] other_irq;
	} nvic_periph_s;

	typedef struct packed {
		logic nmi_req;
		logic fault_req;
		logic svc_req;
		logic system_tick_timer_req;
		logic exc_ack;
		logic exc_return;
	} nvic_core_in_s;

	typedef struct packed {
		logic        req_valid;
		logic [5:0]  req_num;
		logic [31:0] vector;
		logic        save_frame;
		logic        restore_frame;
		logic        wake_req;
		logic [5:0]  active_num;
	} nvic_core_out_s;

	typedef struct packed {
		logic [31:0]       enable;
		logic [47:0]       pend;
		logic [47:0]       active;
		logic [31:0][1:0]  irq_prio;
		logic [1:0]        svc_prio;
		logic [1:0]        defer_prio;
		logic [1:0]        tick_prio;
		nvic_apb_rsp_s     rsp;
		nvic_core_out_s    out;
	} nvic_state_s;

endpackage : nvic_pkg
`default_nettype wire

// ### rtl/nvic_ctrl.sv
// nested vectored interrupt controller with apb register port
//
// Added by the designer: the address map and the APB slave port.
`include "nvic_params.svh"
`default_nettype none

module nvic_ctrl (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire nvic_pkg::nvic_apb_req_s apb_req,
	output var  nvic_pkg::nvic_apb_rsp_s apb_rsp,
	input  wire nvic_pkg::nvic_periph_s  periph,
	input  wire nvic_pkg::nvic_core_in_s core_in,
	output var  nvic_pkg::nvic_core_out_s core_out
);

	nvic_pkg::nvic_state_s st;
	nvic_pkg::nvic_state_s next_st;

	logic [31:0] irq_in;
	logic [47:0] en_all;
	logic [2:0]  cur_rank;
	logic [5:0]  top_num;
	logic [2:0]  best_rank;
	logic [5:0]  best_num;
	logic        take;
	logic        setup;
	logic        wr;
	logic        wr_seten;
	logic        wr_clren;
	logic        wr_setpend;
	logic        wr_clrpend;
	logic        acked;
	logic [31:0] rdata;
	logic        rd_err;

	// urgency of an exception number, smaller is more urgent
	function automatic logic [2:0] rank_of(input logic [5:0] n, input nvic_pkg::nvic_state_s s);
		logic [4:0] idx;
		logic [2:0] r;
		idx = 5'(n - `NVIC_EXC_IRQ_BASE);
		r = `NVIC_RANK_NONE;
		if (n == `NVIC_EXC_NMI) begin
			r = `NVIC_RANK_NMI;
		end else if (n == `NVIC_EXC_FAULT) begin
			r = `NVIC_RANK_FAULT;
		end else if (n == `NVIC_EXC_SVC) begin
			r = `NVIC_RANK_CFG_BASE + {1'b0, s.svc_prio};
		end else if (n == `NVIC_EXC_DEFER) begin
			r = `NVIC_RANK_CFG_BASE + {1'b0, s.defer_prio};
		end else if (n == `NVIC_EXC_TICK) begin
			r = `NVIC_RANK_CFG_BASE + {1'b0, s.tick_prio};
		end else if (n >= `NVIC_EXC_IRQ_BASE) begin
			r = `NVIC_RANK_CFG_BASE + {1'b0, s.irq_prio[idx]};
		end
		return r;
	endfunction : rank_of

	always_comb begin
		next_st = st;
		irq_in = periph.other_irq;
		irq_in[`NVIC_LINE_BROWNOUT] = periph.brownout_irq;
		irq_in[`NVIC_LINE_WATCHDOG] = periph.watchdog_irq;
		irq_in[`NVIC_LINE_EXT_A] = periph.ext_pin_irq_a;
		irq_in[`NVIC_LINE_EXT_B] = periph.ext_pin_irq_b;
		irq_in[`NVIC_LINE_PORT_LOW] = periph.port_group_low_irq;
		irq_in[`NVIC_LINE_PORT_MID] = periph.port_group_mid_irq;
		irq_in[`NVIC_LINE_PORT_HIGH] = periph.port_group_high_irq;
		irq_in[`NVIC_LINE_COMPARATOR] = periph.comparator_irq;
		irq_in[`NVIC_LINE_PWR_WAKE] = periph.power_wakeup_irq;
		en_all = {st.enable, `NVIC_SYS_EN_MASK};

		// running priority: most urgent active handler
		cur_rank = `NVIC_RANK_NONE;
		top_num = 6'h00;
		for (int i = 0; i < `NVIC_EXC_COUNT; i++) begin
			if (st.active[i] && rank_of(6'(i), st) < cur_rank) begin
				cur_rank = rank_of(6'(i), st);
				top_num = 6'(i);
			end
		end

		// strict less-than over ascending numbers keeps the lowest on ties
		best_rank = `NVIC_RANK_NONE;
		best_num = 6'h00;
		for (int i = 0; i < `NVIC_EXC_COUNT; i++) begin
			if (st.pend[i] && !st.active[i] && en_all[i] && rank_of(6'(i), st) < best_rank) begin
				best_rank = rank_of(6'(i), st);
				best_num = 6'(i);
			end
		end
		take = best_rank < cur_rank;

		// apb decode, answer ready in first access cycle
		setup = apb_req.psel && !apb_req.penable;
		wr = apb_req.psel && apb_req.penable && apb_req.pwrite && st.rsp.pready;
		wr_seten = wr && apb_req.paddr == `NVIC_OFF_SETEN;
		wr_clren = wr && apb_req.paddr == `NVIC_OFF_CLREN;
		wr_setpend = wr && apb_req.paddr == `NVIC_OFF_SETPEND;
		wr_clrpend = wr && apb_req.paddr == `NVIC_OFF_CLRPEND;

		rdata = 32'h0000_0000;
		rd_err = 1'b0;
		if (apb_req.paddr == `NVIC_OFF_SETEN || apb_req.paddr == `NVIC_OFF_CLREN) begin
			rdata = st.enable;
		end else if (apb_req.paddr == `NVIC_OFF_SETPEND || apb_req.paddr == `NVIC_OFF_CLRPEND) begin
			rdata = st.pend[47:16];
		end else if (apb_req.paddr[11:5] == 7'(`NVIC_OFF_PRIO_BASE >> 5) && apb_req.paddr[1:0] == 2'h0) begin
			for (int j = 0; j < 4; j++) begin
				rdata[8*j+`NVIC_PRIO_LSB +: 2] = st.irq_prio[{apb_req.paddr[4:2], 2'(j)}];
			end
		end else if (apb_req.paddr == `NVIC_OFF_SYSPRIO2) begin
			rdata[24+`NVIC_PRIO_LSB +: 2] = st.svc_prio;
		end else if (apb_req.paddr == `NVIC_OFF_SYSPRIO3) begin
			rdata[16+`NVIC_PRIO_LSB +: 2] = st.defer_prio;
			rdata[24+`NVIC_PRIO_LSB +: 2] = st.tick_prio;
		end else if (apb_req.paddr == `NVIC_OFF_CTRL) begin
			rdata[`NVIC_CTRL_DEFER_PEND] = st.pend[`NVIC_EXC_DEFER];
			rdata[17:12] = best_num;
			rdata[5:0] = st.out.active_num;
		end else begin
			rd_err = 1'b1;
		end
		next_st.rsp.pready = setup;
		if (setup) begin
			next_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
			next_st.rsp.pslverr = rd_err;
		end

		// register writes
		if (wr_seten) begin
			next_st.enable = st.enable | apb_req.pwdata;
		end
		if (wr_clren) begin
			next_st.enable = st.enable & ~apb_req.pwdata;
		end
		if (wr && apb_req.paddr[11:5] == 7'(`NVIC_OFF_PRIO_BASE >> 5) && apb_req.paddr[1:0] == 2'h0) begin
			for (int j = 0; j < 4; j++) begin
				next_st.irq_prio[{apb_req.paddr[4:2], 2'(j)}] = apb_req.pwdata[8*j+`NVIC_PRIO_LSB +: 2];
			end
		end
		if (wr && apb_req.paddr == `NVIC_OFF_SYSPRIO2) begin
			next_st.svc_prio = apb_req.pwdata[24+`NVIC_PRIO_LSB +: 2];
		end
		if (wr && apb_req.paddr == `NVIC_OFF_SYSPRIO3) begin
			next_st.defer_prio = apb_req.pwdata[16+`NVIC_PRIO_LSB +: 2];
			next_st.tick_prio = apb_req.pwdata[24+`NVIC_PRIO_LSB +: 2];
		end

		// clears first, sets after, so a set in the same cycle wins
		acked = core_in.exc_ack && st.out.req_valid;
		if (wr_clrpend) begin
			next_st.pend[47:16] = st.pend[47:16] & ~apb_req.pwdata;
		end
		if (wr && apb_req.paddr == `NVIC_OFF_CTRL && apb_req.pwdata[`NVIC_CTRL_DEFER_CLR]) begin
			next_st.pend[`NVIC_EXC_DEFER] = 1'b0;
		end
		if (acked) begin
			next_st.active[st.out.req_num] = 1'b1;
			next_st.pend[st.out.req_num] = 1'b0;
		end
		if (core_in.exc_return && |st.active) begin
			next_st.active[top_num] = 1'b0;
		end
		if (wr_setpend) begin
			next_st.pend[47:16] = next_st.pend[47:16] | apb_req.pwdata;
		end
		if (wr && apb_req.paddr == `NVIC_OFF_CTRL && apb_req.pwdata[`NVIC_CTRL_DEFER_SET]) begin
			next_st.pend[`NVIC_EXC_DEFER] = 1'b1;
		end
		next_st.pend[47:16] = next_st.pend[47:16] | irq_in;
		next_st.pend[`NVIC_EXC_NMI] = next_st.pend[`NVIC_EXC_NMI] | core_in.nmi_req;
		next_st.pend[`NVIC_EXC_FAULT] = next_st.pend[`NVIC_EXC_FAULT] | core_in.fault_req;
		next_st.pend[`NVIC_EXC_SVC] = next_st.pend[`NVIC_EXC_SVC] | core_in.svc_req;
		next_st.pend[`NVIC_EXC_TICK] = next_st.pend[`NVIC_EXC_TICK] | core_in.system_tick_timer_req;

		// core side, number and vector follow the best candidate every cycle, also after it is taken
		next_st.out.req_valid = take && !acked;
		next_st.out.req_num = best_num;
		next_st.out.vector = `NVIC_VTOR_BASE + {24'h00_0000, best_num, 2'h0};
		next_st.out.save_frame = acked;
		next_st.out.restore_frame = core_in.exc_return && |st.active;
		next_st.out.wake_req = |(st.pend[47:16] & `NVIC_WAKE_MASK);
		next_st.out.active_num = top_num;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp = st.rsp;
	assign core_out = st.out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_prio_reset;
		$rose(rst_n) |-> (st.irq_prio == '0 && st.svc_prio == 2'h0 && st.tick_prio == 2'h0);
	endproperty
	a_prio_reset: assert property (p_prio_reset)
		else $error("priority not zero after reset");

	property p_vector;
		core_out.req_valid |-> core_out.vector == {24'h00_0000, core_out.req_num, 2'h0};
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector address not number times four");

	property p_set_enable;
		wr_seten |=> (st.enable & $past(apb_req.pwdata)) == $past(apb_req.pwdata);
	endproperty
	a_set_enable: assert property (p_set_enable)
		else $error("set-enable write did not enable");

	property p_clr_enable;
		wr_clren |=> (st.enable & $past(apb_req.pwdata)) == 32'h0000_0000;
	endproperty
	a_clr_enable: assert property (p_clr_enable)
		else $error("clear-enable write did not disable");

	property p_line_pends;
		(irq_in != 32'h0000_0000) |=> (st.pend[47:16] & $past(irq_in)) == $past(irq_in);
	endproperty
	a_line_pends: assert property (p_line_pends)
		else $error("request line did not pend");

	property p_disabled_idle;
		core_out.req_valid && core_out.req_num >= `NVIC_EXC_IRQ_BASE |->
			|($past(st.enable) & (32'h1 << (core_out.req_num - `NVIC_EXC_IRQ_BASE)));
	endproperty
	a_disabled_idle: assert property (p_disabled_idle)
		else $error("disabled interrupt presented");

	property p_active_kept;
		!core_in.exc_return |=> (st.active & $past(st.active)) == $past(st.active);
	endproperty
	a_active_kept: assert property (p_active_kept)
		else $error("active interrupt lost without return");

	property p_clrpend_active;
		wr_clrpend && !core_in.exc_return && !acked |=> st.active == $past(st.active);
	endproperty
	a_clrpend_active: assert property (p_clrpend_active)
		else $error("clear-pending changed active state");

	property p_nmi_first;
		st.pend[2] && !st.active[2] && !acked |=> core_out.req_valid && core_out.req_num == 6'h02;
	endproperty
	a_nmi_first: assert property (p_nmi_first)
		else $error("pending nmi not presented");

	property p_frame_save;
		core_in.exc_ack && core_out.req_valid |=> core_out.save_frame ##1 !core_out.save_frame;
	endproperty
	a_frame_save: assert property (p_frame_save)
		else $error("frame save pulse missing");

	property p_apb_ready;
		setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("apb answer not in first access cycle");

	property p_fault_first;
		st.pend[3] && !st.active[3] && !st.active[2] && !st.pend[2] && !acked |=> core_out.req_valid && core_out.req_num == 6'h03;
	endproperty
	a_fault_first: assert property (p_fault_first)
		else $error("pending fault not presented");

	property p_vector_base;
		core_out.vector[31:8] == 24'h00_0000;
	endproperty
	a_vector_base: assert property (p_vector_base)
		else $error("vector outside table at address zero");

	property p_num_range;
		core_out.req_valid |-> (core_out.req_num >= `NVIC_EXC_IRQ_BASE && core_out.req_num <= 6'h2f) ||
			core_out.req_num inside {`NVIC_EXC_NMI, `NVIC_EXC_FAULT, `NVIC_EXC_SVC, `NVIC_EXC_DEFER, `NVIC_EXC_TICK};
	endproperty
	a_num_range: assert property (p_num_range)
		else $error("presented number not a valid exception");

	property p_wake_brownout;
		st.pend[16+`NVIC_LINE_BROWNOUT] |=> core_out.wake_req;
	endproperty
	a_wake_brownout: assert property (p_wake_brownout)
		else $error("brown-out request did not wake");

	property p_wake_ext;
		st.pend[16+`NVIC_LINE_EXT_A] || st.pend[16+`NVIC_LINE_EXT_B] |=> core_out.wake_req;
	endproperty
	a_wake_ext: assert property (p_wake_ext)
		else $error("external pin request did not wake");

	property p_wake_port;
		st.pend[16+`NVIC_LINE_PORT_LOW] || st.pend[16+`NVIC_LINE_PORT_MID] || st.pend[16+`NVIC_LINE_PORT_HIGH] |=> core_out.wake_req;
	endproperty
	a_wake_port: assert property (p_wake_port)
		else $error("port group request did not wake");

	property p_wake_comparator;
		st.pend[16+`NVIC_LINE_COMPARATOR] |=> core_out.wake_req;
	endproperty
	a_wake_comparator: assert property (p_wake_comparator)
		else $error("comparator request did not wake");

	property p_wake_power;
		st.pend[16+`NVIC_LINE_PWR_WAKE] |=> core_out.wake_req;
	endproperty
	a_wake_power: assert property (p_wake_power)
		else $error("clock controller request did not wake");

	property p_restore_pulse;
		core_in.exc_return && |st.active |=> core_out.restore_frame;
	endproperty
	a_restore_pulse: assert property (p_restore_pulse)
		else $error("frame restore pulse missing");

	property p_return_clears;
		core_in.exc_return && |st.active && !acked |=> $countones(st.active) == $countones($past(st.active)) - 1;
	endproperty
	a_return_clears: assert property (p_return_clears)
		else $error("return did not end exactly one handler");

	property p_ack_active;
		acked |=> |(st.active & (48'h1 << $past(core_out.req_num)));
	endproperty
	a_ack_active: assert property (p_ack_active)
		else $error("accepted exception not active");

	property p_ack_drops;
		acked |=> !core_out.req_valid;
	endproperty
	a_ack_drops: assert property (p_ack_drops)
		else $error("request still valid after accept");

	property p_idle_present;
		!(|st.active) && |(st.pend[47:16] & st.enable) && !acked |=> core_out.req_valid;
	endproperty
	a_idle_present: assert property (p_idle_present)
		else $error("enabled pending line not presented when idle");

	property p_prio_field;
		wr && apb_req.paddr == `NVIC_OFF_PRIO_BASE |=>
			st.irq_prio[0] == $past(apb_req.pwdata[`NVIC_PRIO_MSB:`NVIC_PRIO_LSB]);
	endproperty
	a_prio_field: assert property (p_prio_field)
		else $error("priority field not taken from its byte");

	property p_setpend;
		wr_setpend |=> (st.pend[47:16] & $past(apb_req.pwdata)) == $past(apb_req.pwdata);
	endproperty
	a_setpend: assert property (p_setpend)
		else $error("set-pending write did not pend");

	property p_clrpend;
		wr_clrpend |=> (st.pend[47:16] & $past(apb_req.pwdata) & ~$past(irq_in)) == 32'h0000_0000;
	endproperty
	a_clrpend: assert property (p_clrpend)
		else $error("clear-pending write did not unpend");

endmodule : nvic_ctrl
`default_nettype wire

// ### testbench/nvic_core_model.sv
// processor core and interrupt source model facing the controller
`default_nettype none
module nvic_core_model (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [31:0]              lines,
	input  wire logic [3:0]               sys,
	input  wire logic                     ret,
	input  var  int                       dly,
	input  wire nvic_pkg::nvic_core_out_s core_out,
	output var  nvic_pkg::nvic_core_in_s  core_in,
	output var  nvic_pkg::nvic_periph_s   periph
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ack;
	int   cnt;
	always_comb begin
		periph = {lines[0], lines[1], lines[2], lines[3], lines[4], lines[5], lines[16], lines[25], lines[28], lines};
		core_in = {sys[3], sys[2], sys[1], sys[0], ack, ret};
	end
	// ack once after dly cycles of a standing request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			cnt <= 0;
		end else if (ack || core_out.req_valid !== 1'b1) begin
			ack <= 1'b0;
			cnt <= 0;
		end else if (cnt >= dly) begin
			ack <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : nvic_core_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the interrupt controller
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                     clk;
	logic                     rst_n;
	logic [31:0]              lines;
	logic [3:0]               sys;
	logic                     ret;
	int                       dly;
	nvic_pkg::nvic_apb_req_s  apb_req;
	nvic_pkg::nvic_apb_rsp_s  apb_rsp;
	nvic_pkg::nvic_periph_s   periph;
	nvic_pkg::nvic_core_in_s  core_in;
	nvic_pkg::nvic_core_out_s core_out;
	logic [31:0]              rdat;
	logic                     serr;
	int                       checks;
	int                       miscompares;
	int                       nsave;
	int                       nrest;
	int                       wk[8] = '{0, 2, 3, 4, 5, 16, 25, 28};

	nvic_ctrl u_nvic_ctrl (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.periph(periph), .core_in(core_in), .core_out(core_out));
	nvic_core_model u_nvic_core_model (.clk(clk), .rst_n(rst_n), .lines(lines), .sys(sys), .ret(ret),
		.dly(dly), .core_out(core_out), .core_in(core_in), .periph(periph));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (core_out.save_frame === 1'b1) nsave++;
		if (core_out.restore_frame === 1'b1) nrest++;
	end

	task report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		apb_req <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (apb_rsp.pready !== 1'b1);
		rdat = apb_rsp.prdata;
		serr = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task wait_req;
		for (int i = 0; i < 20 && core_out.req_valid !== 1'b1; i++) @(posedge clk);
	endtask : wait_req

	task pulse(input logic [3:0] s);
		sys <= s;
		@(posedge clk);
		sys <= 4'h0;
		wt(3);
	endtask : pulse

	task take;
		int n;
		n = nsave;
		dly <= 0;
		for (int i = 0; i < 20 && nsave == n; i++) @(posedge clk);
		dly <= 255;
		@(posedge clk);
	endtask : take

	task back;
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		wt(3);
	endtask : back

	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end

	initial begin
		rst_n = 1'b0;
		lines = '0;
		sys = 4'h0;
		ret = 1'b0;
		dly = 255;
		apb_req = '0;
		wt(12);
		rst_n <= 1'b1;
		apb(1'b0, 12'h400, 32'h0);
		chk("prio reset", rdat, 32'h0);
		apb(1'b1, 12'h100, 32'h0000_0180);
		apb(1'b1, 12'h180, 32'h0000_0100);
		apb(1'b0, 12'h180, 32'h0);
		chk("enable", rdat, 32'h0000_0080);
		apb(1'b1, 12'h404, 32'hffff_ffff);
		apb(1'b0, 12'h404, 32'h0);
		chk("prio fields", rdat, 32'hc0c0_c0c0);
		lines <= 32'h0000_0040;
		wt(3);
		apb(1'b0, 12'h200, 32'h0);
		chk("pend disabled", rdat, 32'h0000_0040);
		chk("no request", core_out.req_valid, 32'h0);
		chk("no wake", core_out.wake_req, 32'h0);
		lines <= '0;
		apb(1'b1, 12'h280, 32'h0000_0040);
		apb(1'b1, 12'h200, 32'h0000_0200);
		apb(1'b0, 12'h280, 32'h0);
		chk("set pend", rdat, 32'h0000_0200);
		apb(1'b1, 12'h280, 32'h0000_0200);
		apb(1'b0, 12'h200, 32'h0);
		chk("clear pend", rdat, 32'h0);
		foreach (wk[i]) begin
			lines <= 32'h1 << wk[i];
			wt(3);
			chk("wake", core_out.wake_req, 32'h1);
			apb(1'b0, 12'h200, 32'h0);
			chk("wake pend", rdat, 32'h1 << wk[i]);
			lines <= '0;
			apb(1'b1, 12'h280, 32'h1 << wk[i]);
		end
		lines <= 32'h0000_0080;
		wait_req;
		chk("number", core_out.req_num, 32'd23);
		chk("vector", core_out.vector, 32'h0000_005c);
		lines <= '0;
		take;
		chk("save", nsave, 32'd1);
		chk("active", core_out.active_num, 32'd23);
		apb(1'b1, 12'h100, 32'h0000_0300);
		lines <= 32'h0000_0300;
		wait_req;
		chk("preempt", core_out.req_num, 32'd24);
		pulse(4'h8);
		chk("late nmi", core_out.req_num, 32'd2);
		take;
		chk("nmi active", core_out.active_num, 32'd2);
		back;
		chk("restore", nrest, 32'd1);
		take;
		lines <= '0;
		apb(1'b1, 12'h180, 32'h0000_0100);
		apb(1'b1, 12'h280, 32'h0000_0100);
		wt(2);
		chk("still active", core_out.active_num, 32'd24);
		back;
		chk("next", core_out.req_num, 32'd25);
		pulse(4'h2);
		chk("svc", core_out.req_num, 32'd11);
		chk("svc vector", core_out.vector, 32'h0000_002c);
		take;
		back;
		apb(1'b1, 12'hd04, 32'h1000_0000);
		wt(2);
		chk("deferred", core_out.req_num, 32'd14);
		take;
		back;
		apb(1'b1, 12'hd20, 32'hc000_0000);
		apb(1'b0, 12'hd20, 32'h0);
		chk("tick prio", rdat, 32'hc000_0000);
		pulse(4'h1);
		chk("tick ranked", core_out.req_num, 32'd25);
		apb(1'b1, 12'hd1c, 32'hc000_0000);
		apb(1'b0, 12'hd1c, 32'h0);
		chk("svc prio", rdat, 32'hc000_0000);
		apb(1'b1, 12'h400, 32'h0000_c000);
		apb(1'b1, 12'h280, 32'h0000_0200);
		apb(1'b1, 12'h100, 32'h0002_0000);
		lines <= 32'h0002_0000;
		wt(3);
		chk("upper line", core_out.req_num, 32'd33);
		chk("upper request", core_out.req_valid, 32'h1);
		lines <= '0;
		pulse(4'h4);
		chk("fault", core_out.req_num, 32'd3);
		apb(1'b1, 12'hd04, 32'h1000_0000);
		apb(1'b0, 12'hd04, 32'h0);
		chk("ctrl pend", rdat, 32'h0400_3017);
		apb(1'b1, 12'hd04, 32'h0800_0000);
		apb(1'b0, 12'hd04, 32'h0);
		chk("ctrl clear", rdat, 32'h0000_3017);
		apb(1'b0, 12'h300, 32'h0);
		chk("unmapped", serr, 32'h1);
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
